/* File: design/psi_defs.svh */
// Register offsets, field positions and reset values of the packet start indicator
`ifndef PSI_DEFS_SVH
`define PSI_DEFS_SVH

`define PSI_ADDR_TX_SYNC   16'h9427
`define PSI_ADDR_CTRL      16'h9428
`define PSI_ADDR_RX_DELAY  16'h9429

`define PSI_RST_TX_SYNC    16'h0000
`define PSI_RST_CTRL       16'h0034
`define PSI_RST_RX_DELAY   16'h0000

`define PSI_MASK_TX_SYNC   16'h0001
`define PSI_MASK_CTRL      16'h007F
`define PSI_MASK_RX_DELAY  16'hFFFF

`define PSI_SYNC_BIT       0
`define PSI_LEN_HI         6
`define PSI_LEN_LO         4
`define PSI_FIXED_BIT      3
`define PSI_SFD_BIT        2
`define PSI_RX_EN_BIT      1
`define PSI_TX_EN_BIT      0

`define PSI_D10_HI         15
`define PSI_D10_LO         11
`define PSI_D100_HI        10
`define PSI_D100_LO        6
`define PSI_D1G_HI         5
`define PSI_D1G_LO         0

`define PSI_LEN_UNIT       8

`endif

/* File: design/psi_pkg.sv */
// Types shared by the packet start indicator modules
package psi_pkg;

  typedef enum logic [1:0] {PSI_SPEED_10M, PSI_SPEED_100M, PSI_SPEED_1G} psi_speed_e;

  typedef enum logic {PSI_IDLE, PSI_ACTIVE} psi_pulse_e;

  typedef logic [15:0] psi_word_t;

  typedef struct packed {
    psi_word_t tx_sync;
    psi_word_t ctrl;
    psi_word_t rx_delay;
    psi_word_t rdata;
    logic      rx_frame_d;
    logic      tx_frame_d;
    logic      tx_sync_out;
  } psi_top_s;

endpackage

/* File: design/psi_delay_line.sv */
// Programmable delay of a one-cycle start event
`timescale 1ns/1ps
`default_nettype none

module psi_delay_line
  import psi_pkg::*;
#(
  parameter int DEPTH = 63,
  parameter int SEL_W = 6
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // Event in, delay, event out
  input  wire logic             i_event,
  input  wire logic [SEL_W-1:0] i_delay,
  output logic                  o_event
);

  typedef struct packed {
    logic [DEPTH-1:0] taps;
  } psi_delay_s;

  psi_delay_s st;
  psi_delay_s next_st;

  if (DEPTH < 2 || DEPTH < (2 ** SEL_W) - 1) begin : g_check
    $error("psi_delay_line: DEPTH cannot serve the delay field");
  end

  always_comb begin
    next_st      = st;
    next_st.taps = {st.taps[DEPTH-2:0], i_event};
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_event = (i_delay == '0) ? i_event : st.taps[int'(i_delay) - 1];

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_zero_delay_pass: assert property ((i_delay == '0) |-> (o_event == i_event))
    else $error("zero delay does not pass the event through");

  a_delay_two_taps: assert property (i_event ##2 (i_delay == SEL_W'(2)) |-> o_event)
    else $error("event not delayed by two cycles");

endmodule // psi_delay_line

`default_nettype wire

/* File: design/psi_pulse_gen.sv */
// One start-of-packet pulse: whole frame or fixed length
`timescale 1ns/1ps
`default_nettype none

`include "psi_defs.svh"

module psi_pulse_gen
  import psi_pkg::*;
#(
  parameter int LEN_W = 3
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // Configuration
  input  wire logic             i_enable,
  input  wire logic             i_fixed,
  input  wire logic [LEN_W-1:0] i_len,
  // Frame and start event
  input  wire logic             i_frame,
  input  wire logic             i_start,
  // Pulse
  output logic                  o_pulse
);

  localparam int CW = LEN_W + 3;

  typedef struct packed {
    psi_pulse_e      state;
    logic            pulse;
    logic [CW-1:0]   count;
  } psi_pulse_s;

  psi_pulse_s    st;
  psi_pulse_s    next_st;
  logic [CW-1:0] limit;

  if (LEN_W < 1 || `PSI_LEN_UNIT != 8) begin : g_check
    $error("psi_pulse_gen: length field cannot be served");
  end

  assign limit = CW'((int'(i_len) + 1) * `PSI_LEN_UNIT - 1);

  always_comb begin
    next_st = st;
    unique case (st.state)
      PSI_IDLE: begin
        if (i_enable && i_frame && i_start) begin
          next_st.state = PSI_ACTIVE;
          next_st.pulse = 1'b1;
          next_st.count = '0;
        end
      end
      PSI_ACTIVE: begin
        next_st.count = st.count + 1'b1;
        if (!i_enable || !i_frame || (i_fixed && st.count >= limit)) begin
          next_st.state = PSI_IDLE;
          next_st.pulse = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '{state: PSI_IDLE, pulse: 1'b0, count: '0};
    end else begin
      st <= next_st;
    end
  end

  assign o_pulse = st.pulse;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_idle_start;
    !o_pulse && i_enable && i_frame && i_start;
  endsequence

  sequence s_running;
    o_pulse && i_enable && i_frame;
  endsequence

  a_start_taken: assert property (s_idle_start |=> o_pulse)
    else $error("start event did not raise the pulse");

  a_frame_end_drop: assert property (!i_frame |=> !o_pulse)
    else $error("pulse outlived its frame");

  a_disabled_quiet: assert property (!i_enable |=> !o_pulse)
    else $error("pulse while disabled");

  a_whole_frame_hold: assert property (s_running ##0 !i_fixed |=> o_pulse)
    else $error("whole-frame pulse dropped early");

  a_fixed_len_end: assert property (o_pulse && i_fixed && st.count == limit |=> !o_pulse)
    else $error("fixed pulse not ended at its length");

  a_fixed_len_hold: assert property (s_running ##0 i_fixed && st.count < limit |=> o_pulse)
    else $error("fixed pulse dropped before its length");

endmodule // psi_pulse_gen

`default_nettype wire

/* File: design/psi_top.sv */
// Packet start indicator: registers, triggers, receive delay and pulses
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

`include "psi_defs.svh"

module psi_top
  import psi_pkg::*;
#(
  parameter int DELAY_W = 6,
  parameter int LEN_W   = 3
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Register port
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Receive path
  input  wire logic        i_rx_frame,
  input  wire logic        i_rx_sfd,
  // Transmit buffer output side
  input  wire logic        i_tx_frame,
  input  wire logic        i_tx_sfd,
  // Link state
  input  wire psi_speed_e  i_speed,
  input  wire logic        i_gig_slave,
  // Indications
  output logic             o_rx_packet_start_pulse,
  output logic             o_tx_packet_start_pulse,
  output logic             o_tx_buffer_sync
);

  localparam int DEPTH = (2 ** DELAY_W) - 1;

  if (DELAY_W < 6 || LEN_W != (`PSI_LEN_HI - `PSI_LEN_LO + 1)) begin : g_check
    $error("psi_top: field widths cannot be served");
  end

  psi_top_s             st;
  psi_top_s             next_st;
  logic [DELAY_W-1:0]   rx_delay_sel;
  logic [LEN_W-1:0]     pulse_length_field;
  logic                 fixed_length_select;
  logic                 delimiter_trigger_select;
  logic                 rx_pulse_enable;
  logic                 tx_pulse_enable;
  logic                 rx_trigger;
  logic                 tx_trigger;
  logic                 rx_start;

  // Control fields
  assign pulse_length_field       = st.ctrl[`PSI_LEN_HI:`PSI_LEN_LO];
  assign fixed_length_select      = st.ctrl[`PSI_FIXED_BIT];
  assign delimiter_trigger_select = st.ctrl[`PSI_SFD_BIT];
  assign rx_pulse_enable          = st.ctrl[`PSI_RX_EN_BIT];
  assign tx_pulse_enable          = st.ctrl[`PSI_TX_EN_BIT];

  // delimiter or first byte
  // Bit flips mid-frame can fire twice; software keeps it still
  assign rx_trigger = delimiter_trigger_select ? i_rx_sfd
                                               : (i_rx_frame && !st.rx_frame_d);

  assign tx_trigger = delimiter_trigger_select ? i_tx_sfd
                                               : (i_tx_frame && !st.tx_frame_d);

  always_comb begin
    unique case (i_speed)
      PSI_SPEED_10M:  rx_delay_sel = DELAY_W'(st.rx_delay[`PSI_D10_HI:`PSI_D10_LO]);
      PSI_SPEED_100M: rx_delay_sel = DELAY_W'(st.rx_delay[`PSI_D100_HI:`PSI_D100_LO]);
      PSI_SPEED_1G:   rx_delay_sel = DELAY_W'(st.rx_delay[`PSI_D1G_HI:`PSI_D1G_LO]);
      default:        rx_delay_sel = '0;
    endcase
  end

  always_comb begin
    next_st            = st;
    next_st.rx_frame_d = i_rx_frame;
    next_st.tx_frame_d = i_tx_frame;
    // Read data stand one cycle only
    next_st.rdata      = '0;
    if (i_wr) begin
      case (i_addr)
        `PSI_ADDR_TX_SYNC:  next_st.tx_sync  = i_wdata & `PSI_MASK_TX_SYNC;
        `PSI_ADDR_CTRL:     next_st.ctrl     = i_wdata & `PSI_MASK_CTRL;
        `PSI_ADDR_RX_DELAY: next_st.rx_delay = i_wdata & `PSI_MASK_RX_DELAY;
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `PSI_ADDR_TX_SYNC:  next_st.rdata = st.tx_sync;
        `PSI_ADDR_CTRL:     next_st.rdata = st.ctrl;
        `PSI_ADDR_RX_DELAY: next_st.rdata = st.rx_delay;
        default:            next_st.rdata = '0;
      endcase
    end
    next_st.tx_sync_out = st.tx_sync[`PSI_SYNC_BIT]
                          && !(i_speed == PSI_SPEED_1G && i_gig_slave);
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '{tx_sync:     `PSI_RST_TX_SYNC,
              ctrl:        `PSI_RST_CTRL,
              rx_delay:    `PSI_RST_RX_DELAY,
              rdata:       16'h0000,
              rx_frame_d:  1'b0,
              tx_frame_d:  1'b0,
              tx_sync_out: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata          = st.rdata;
  assign o_tx_buffer_sync = st.tx_sync_out;

  psi_delay_line #(
    .DEPTH (DEPTH),
    .SEL_W (DELAY_W)
  ) u_rx_delay (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_event (rx_trigger),
    .i_delay (rx_delay_sel),
    .o_event (rx_start)
  );

  psi_pulse_gen #(
    .LEN_W (LEN_W)
  ) u_rx_pulse (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_enable (rx_pulse_enable),
    .i_fixed  (fixed_length_select),
    .i_len    (pulse_length_field),
    .i_frame  (i_rx_frame),
    .i_start  (rx_start),
    .o_pulse  (o_rx_packet_start_pulse)
  );

  psi_pulse_gen #(
    .LEN_W (LEN_W)
  ) u_tx_pulse (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_enable (tx_pulse_enable),
    .i_fixed  (fixed_length_select),
    .i_len    (pulse_length_field),
    .i_frame  (i_tx_frame),
    .i_start  (tx_trigger),
    .o_pulse  (o_tx_packet_start_pulse)
  );

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_rx_start_quiet;
    !o_rx_packet_start_pulse && rx_pulse_enable && i_rx_frame && rx_trigger
    && !fixed_length_select && rx_delay_sel == DELAY_W'(3);
  endsequence

  sequence s_rx_hold_three;
    (i_rx_frame && rx_pulse_enable && !fixed_length_select
     && rx_delay_sel == DELAY_W'(3))[*3];
  endsequence

  a_rx_enable_gate: assert property (!rx_pulse_enable |=> !o_rx_packet_start_pulse)
    else $error("receive pulse while receive enable clear");

  a_tx_enable_gate: assert property (!tx_pulse_enable |=> !o_tx_packet_start_pulse)
    else $error("transmit pulse while transmit enable clear");

  a_rx_sfd_start: assert property (rx_pulse_enable && delimiter_trigger_select
      && rx_delay_sel == '0 && i_rx_frame && i_rx_sfd && !o_rx_packet_start_pulse
      |=> o_rx_packet_start_pulse)
    else $error("delimiter did not start receive pulse");

  a_tx_edge_start: assert property (tx_pulse_enable && !delimiter_trigger_select
      && i_tx_frame && !st.tx_frame_d && !o_tx_packet_start_pulse
      |=> o_tx_packet_start_pulse)
    else $error("buffer output frame start missed");

  a_tx_sfd_only: assert property (tx_pulse_enable && delimiter_trigger_select
      && !i_tx_sfd && !o_tx_packet_start_pulse |=> !o_tx_packet_start_pulse)
    else $error("transmit pulse without delimiter");

  a_rx_delay_three: assert property (s_rx_start_quiet ##1 s_rx_hold_three
      |=> o_rx_packet_start_pulse)
    else $error("receive pulse not raised after three cycle delay");

  a_rx_delay_wait: assert property (s_rx_start_quiet |=> !o_rx_packet_start_pulse)
    else $error("delayed receive pulse came early");

  a_buffer_slave_async: assert property (i_gig_slave && i_speed == PSI_SPEED_1G
      |=> !o_tx_buffer_sync)
    else $error("buffer synchronous as gigabit slave");

  a_buffer_sync_on: assert property (st.tx_sync[0] && i_speed != PSI_SPEED_1G
      |=> o_tx_buffer_sync)
    else $error("buffer not synchronous when requested");

  a_buffer_sync_off: assert property (!st.tx_sync[0] |=> !o_tx_buffer_sync)
    else $error("buffer synchronous without request");

  a_rx_frame_end: assert property (!i_rx_frame |=> !o_rx_packet_start_pulse)
    else $error("receive pulse outlived its frame");

  a_tx_frame_end: assert property (!i_tx_frame |=> !o_tx_packet_start_pulse)
    else $error("transmit pulse outlived its frame");

  a_rx_whole_hold: assert property (o_rx_packet_start_pulse && i_rx_frame
      && rx_pulse_enable && !fixed_length_select |=> o_rx_packet_start_pulse)
    else $error("whole-frame receive pulse dropped early");

  a_tx_whole_hold: assert property (o_tx_packet_start_pulse && i_tx_frame
      && tx_pulse_enable && !fixed_length_select |=> o_tx_packet_start_pulse)
    else $error("whole-frame transmit pulse dropped early");

  a_tx_sfd_start: assert property (tx_pulse_enable && delimiter_trigger_select
      && i_tx_frame && i_tx_sfd && !o_tx_packet_start_pulse
      |=> o_tx_packet_start_pulse)
    else $error("delimiter did not start transmit pulse");

  a_rx_edge_start: assert property (rx_pulse_enable && !delimiter_trigger_select
      && rx_delay_sel == '0 && i_rx_frame && !st.rx_frame_d && !o_rx_packet_start_pulse
      |=> o_rx_packet_start_pulse)
    else $error("first receive byte did not start pulse");

  // Each speed must read its own delay field, not a neighbour's
  sequence s_rx_quiet_10m;
    !o_rx_packet_start_pulse && rx_pulse_enable && i_rx_frame && rx_trigger
    && !fixed_length_select && i_speed == PSI_SPEED_10M
    && st.rx_delay[`PSI_D10_HI:`PSI_D10_LO] == 5'h03;
  endsequence

  sequence s_rx_keep_10m;
    (i_rx_frame && rx_pulse_enable && !fixed_length_select && i_speed == PSI_SPEED_10M
     && st.rx_delay[`PSI_D10_HI:`PSI_D10_LO] == 5'h03)[*3];
  endsequence

  sequence s_rx_quiet_100m;
    !o_rx_packet_start_pulse && rx_pulse_enable && i_rx_frame && rx_trigger
    && !fixed_length_select && i_speed == PSI_SPEED_100M
    && st.rx_delay[`PSI_D100_HI:`PSI_D100_LO] == 5'h05;
  endsequence

  sequence s_rx_keep_100m;
    (i_rx_frame && rx_pulse_enable && !fixed_length_select && i_speed == PSI_SPEED_100M
     && st.rx_delay[`PSI_D100_HI:`PSI_D100_LO] == 5'h05)[*5];
  endsequence

  sequence s_rx_quiet_1g;
    !o_rx_packet_start_pulse && rx_pulse_enable && i_rx_frame && rx_trigger
    && !fixed_length_select && i_speed == PSI_SPEED_1G
    && st.rx_delay[`PSI_D1G_HI:`PSI_D1G_LO] == 6'h07;
  endsequence

  sequence s_rx_keep_1g;
    (i_rx_frame && rx_pulse_enable && !fixed_length_select && i_speed == PSI_SPEED_1G
     && st.rx_delay[`PSI_D1G_HI:`PSI_D1G_LO] == 6'h07)[*7];
  endsequence

  a_rx_delay_10m: assert property (s_rx_quiet_10m ##1 s_rx_keep_10m
      |=> o_rx_packet_start_pulse)
    else $error("receive pulse not delayed by the 10M field");

  a_rx_delay_100m: assert property (s_rx_quiet_100m ##1 s_rx_keep_100m
      |=> o_rx_packet_start_pulse)
    else $error("receive pulse not delayed by the 100M field");

  a_rx_delay_1g: assert property (s_rx_quiet_1g ##1 s_rx_keep_1g
      |=> o_rx_packet_start_pulse)
    else $error("receive pulse not delayed by the gigabit field");

  a_rdata_one_cycle: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside the read answer cycle");

  a_ctrl_readback: assert property (i_wr && i_addr == `PSI_ADDR_CTRL ##1 i_rd
      && i_addr == `PSI_ADDR_CTRL |=> o_rdata == ($past(i_wdata, 2) & `PSI_MASK_CTRL))
    else $error("control register read back wrong");

endmodule // psi_top

`default_nettype wire

/* File: verification/psi_frame_model.sv */
// Frame source standing in for the link side of one path
`timescale 1ns/1ps
`default_nettype none

module psi_frame_model (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Frame request
  input  wire logic       i_go,
  input  wire logic [7:0] i_len,
  input  wire logic [7:0] i_sfd_pos,
  // Frame and delimiter
  output logic            o_frame,
  output logic            o_sfd
);
  logic [7:0] idx;
  logic       act;

  // Frame valid low between frames, delimiter lasts one cycle
  assign o_frame = act;
  assign o_sfd   = act && (idx == i_sfd_pos);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      act <= 1'b0;
      idx <= 8'h00;
    end else if (i_go) begin
      act <= 1'b1;
      idx <= 8'h00;
    end else if (act) begin
      idx <= idx + 8'h01;
      if (idx == i_len - 8'h01) begin
        act <= 1'b0;
      end
    end
  end
endmodule // psi_frame_model

`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench of the packet start indicator
`timescale 1ns/1ps
`default_nettype none

`include "psi_defs.svh"

module tb_top
  import psi_pkg::*;
;
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic [15:0] i_addr  = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  psi_speed_e  i_speed = PSI_SPEED_1G;
  logic        slave   = 1'b0;
  logic        rx_go   = 1'b0;
  logic        tx_go   = 1'b0;
  logic [7:0]  f_len   = 8'h01;
  logic [7:0]  f_pos   = 8'h00;
  logic [15:0] ctl     = 16'h0034;
  logic [15:0] o_rdata;
  logic        rx_frame, rx_sfd, tx_frame, tx_sfd;
  logic        o_rx, o_tx, o_sync;
  int          num_errors  = 0;
  int          check_count = 0;

  always #5 i_clock = ~i_clock;

  psi_top #(.DELAY_W(6), .LEN_W(3)) uut (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rx_frame(rx_frame), .i_rx_sfd(rx_sfd), .i_tx_frame(tx_frame), .i_tx_sfd(tx_sfd),
    .i_speed(i_speed), .i_gig_slave(slave),
    .o_rx_packet_start_pulse(o_rx), .o_tx_packet_start_pulse(o_tx),
    .o_tx_buffer_sync(o_sync));

  psi_frame_model u_rx_src (.i_clock(i_clock), .i_rst(i_rst), .i_go(rx_go),
    .i_len(f_len), .i_sfd_pos(f_pos), .o_frame(rx_frame), .o_sfd(rx_sfd));
  psi_frame_model u_tx_src (.i_clock(i_clock), .i_rst(i_rst), .i_go(tx_go),
    .i_len(f_len), .i_sfd_pos(f_pos), .o_frame(tx_frame), .o_sfd(tx_sfd));

  task automatic stop_test();
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    chk(o_rdata, exp);
  endtask

  // enables off before the trigger bit moves
  task automatic set_ctrl(input logic [15:0] v);
    wr(`PSI_ADDR_CTRL, ctl & 16'hFFFC);
    wr(`PSI_ADDR_CTRL, v & 16'hFFFC);
    wr(`PSI_ADDR_CTRL, v);
    ctl = v;
  endtask

  // Sends one frame, checks delay from trigger to pulse and pulse width
  task automatic run(input bit rx, input int len, input int s, input int lat, input int wid);
    int t;
    int first;
    int w;
    logic trig;
    t = -1;
    first = -1;
    w = 0;
    @(posedge i_clock);
    f_len <= len[7:0];
    f_pos <= s[7:0];
    if (rx) rx_go <= 1'b1;
    else tx_go <= 1'b1;
    @(posedge i_clock);
    rx_go <= 1'b0;
    tx_go <= 1'b0;
    for (int k = 0; k < len + 80; k++) begin
      @(negedge i_clock);
      if (rx) trig = ctl[`PSI_SFD_BIT] ? rx_sfd : rx_frame;
      else trig = ctl[`PSI_SFD_BIT] ? tx_sfd : tx_frame;
      if (t < 0 && trig) t = k;
      if (rx ? o_rx : o_tx) begin
        if (first < 0) first = k;
        w++;
      end
    end
    if (wid > 0) chk(16'(first - t), 16'(lat));
    chk(16'(w), 16'(wid));
  endtask

  task automatic t_regs();
    rd(`PSI_ADDR_TX_SYNC, 16'h0000);
    rd(`PSI_ADDR_CTRL, 16'h0034);
    rd(`PSI_ADDR_RX_DELAY, 16'h0000);
    wr(`PSI_ADDR_CTRL, 16'hFFFF);
    rd(`PSI_ADDR_CTRL, 16'h007F);
    ctl = 16'h007F;
    wr(`PSI_ADDR_RX_DELAY, 16'hFFFF);
    rd(`PSI_ADDR_RX_DELAY, 16'hFFFF);
    wr(`PSI_ADDR_RX_DELAY, 16'h0000);
    // Unmapped place reads zero
    wr(16'h942A, 16'hFFFF);
    rd(16'h942A, 16'h0000);
  endtask

  task automatic t_tx();
    set_ctrl(16'h0009);
    run(0, 20, 0, 1, 8);
    run(1, 20, 0, 0, 0);
    set_ctrl(16'h0029);
    run(0, 40, 0, 1, 24);
    set_ctrl(16'h0079);
    run(0, 30, 0, 1, 30);
  endtask

  task automatic t_rx();
    psi_speed_e sp[3];
    int nd[3];
    sp = '{PSI_SPEED_10M, PSI_SPEED_100M, PSI_SPEED_1G};
    nd = '{3, 5, 7};
    set_ctrl(16'h0002);
    run(1, 30, 4, 1, 30);
    set_ctrl(16'h0006);
    run(1, 30, 4, 1, 26);
    run(0, 30, 4, 0, 0);
    // Distinct delay in each speed field: 3, 5 and 7
    wr(`PSI_ADDR_RX_DELAY, 16'h1947);
    for (int m = 0; m < 3; m++) begin
      @(posedge i_clock);
      i_speed <= sp[m];
      run(1, 30, 4, 1 + nd[m], 26 - nd[m]);
    end
  endtask

  task automatic t_sync();
    wr(`PSI_ADDR_TX_SYNC, 16'hFFFF);
    rd(`PSI_ADDR_TX_SYNC, 16'h0001);
    for (int m = 0; m < 4; m++) begin
      @(posedge i_clock);
      i_speed <= m[0] ? PSI_SPEED_1G : PSI_SPEED_100M;
      slave   <= m[1];
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      chk({15'h0000, o_sync}, {15'h0000, m != 3});
    end
  endtask

  initial begin
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_sync();
    stop_test();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
